/* hw/tmr_pkg.sv */
/*
  Constants, types and helper functions for the measurand telegram responder.
  Assumes a single 50 MHz core clock and registers reached over Avalon-MM.
*/
// What this block does
// [R01] Status nibble in byte 0, zero means OK
// [R02] Nonzero status: no user data, length zero
// [R03] Highest applicable error code wins
// [R04] Codes 1 refresh, 2 tag, 3 length
// [R05] Codes 4 too big, 5 undefined, 6 measurand
// [R06] Codes 7 command failed, 8 bad definition
// [R07] Codes 9 bad type, 0A bad parameters
// [R08] Codes 0E external, 0F internal disturbance
// [R09] Common status carries seven limit flags
// [R10] Type in byte 0 bits 6..4
// [R11] Types zero frame, value, frame read
// [R12] Types define frame, command, parameter read
// [R13] Zero frame equals read of frame 0
// [R14] Automatic frame 0 polling while exchange runs; polls start here only when idle with no go pending
// [R15] Value request layout set by head module
// [R16] Value read ignores status, common, user bytes
// [R17] Value response echoes type and measurand
// [R18] Byte 2 holds byte count and tag
// [R19] Value bytes ordered by configured endianness
// [R20] Telegrams are sixteen bytes, four header
// [R21] Requests in output, responses in input area
// [R22] Measurand identifiers range one to forty-one
// [R23] Response replaced whole after new decode
package tmr_pkg;

  // ==========================================================
  // Telegram geometry
  localparam int unsigned TMR_TELE_BYTES   = 16;
  localparam int unsigned TMR_HDR_BYTES    = 4;
  localparam int unsigned TMR_USER_BYTES   = 12;
  localparam int unsigned TMR_LANES        = 4;
  localparam int unsigned TMR_FRAMES       = 4;
  localparam int unsigned TMR_ENTRIES      = 4;
  localparam int unsigned TMR_TYPE_LSB     = 4;
  localparam int unsigned TMR_NIB_HI       = 4;
  localparam logic [7:0]  TMR_ID_MIN       = 8'h01;
  localparam logic [7:0]  TMR_ID_MAX       = 8'h29;

  // ==========================================================
  // Status codes
  localparam logic [3:0] TMR_ST_OK        = 4'h0;
  localparam logic [3:0] TMR_ST_REFRESH   = 4'h1;
  localparam logic [3:0] TMR_ST_TAG       = 4'h2;
  localparam logic [3:0] TMR_ST_LENGTH    = 4'h3;
  localparam logic [3:0] TMR_ST_TOO_BIG   = 4'h4;
  localparam logic [3:0] TMR_ST_NO_FRAME  = 4'h5;
  localparam logic [3:0] TMR_ST_NO_MEAS   = 4'h6;
  localparam logic [3:0] TMR_ST_CMD_FAIL  = 4'h7;
  localparam logic [3:0] TMR_ST_BAD_DEF   = 4'h8;
  localparam logic [3:0] TMR_ST_BAD_TYPE  = 4'h9;
  localparam logic [3:0] TMR_ST_BAD_PARAM = 4'ha;
  localparam logic [3:0] TMR_ST_EXTERNAL  = 4'he;
  localparam logic [3:0] TMR_ST_INTERNAL  = 4'hf;

  // ==========================================================
  // Telegram types, bits 6..4 of header byte 0
  localparam logic [2:0] TMR_TY_ZERO      = 3'h0;
  localparam logic [2:0] TMR_TY_VALUE     = 3'h1;
  localparam logic [2:0] TMR_TY_RD_FRAME  = 3'h2;
  localparam logic [2:0] TMR_TY_SET_FRAME = 3'h3;
  localparam logic [2:0] TMR_TY_CMD       = 3'h4;
  localparam logic [2:0] TMR_TY_PARAM     = 3'h6;

  // ==========================================================
  // Register map (byte addresses) and fields
  localparam logic [5:0] TMR_REQ_BASE     = 6'h00;
  localparam logic [5:0] TMR_RSP_BASE     = 6'h10;
  localparam logic [5:0] TMR_CTRL_ADDR    = 6'h20;
  localparam logic [5:0] TMR_STAT_ADDR    = 6'h24;
  localparam int unsigned TMR_CTRL_GO      = 0;
  localparam int unsigned TMR_CTRL_BIG     = 1;
  localparam int unsigned TMR_CTRL_POLL    = 2;
  localparam int unsigned TMR_CTRL_NOPARAM = 3;
  localparam logic       TMR_BIG_RST      = 1'b1;
  localparam logic       TMR_POLL_RST     = 1'b0;
  localparam logic       TMR_NOPARAM_RST  = 1'b0;
  localparam int unsigned TMR_STAT_BUSY    = 0;
  localparam int unsigned TMR_STAT_LAST    = 4;
  localparam int unsigned TMR_STAT_DEF     = 8;

  // ==========================================================
  // Timing
  localparam int unsigned TMR_CLK_HZ       = 50_000_000;
  localparam int unsigned TMR_POLL_US      = 1000;
  localparam int unsigned TMR_POLL_CYCLES  = TMR_POLL_US * (TMR_CLK_HZ / 1_000_000);

  typedef enum logic [1:0] {
    TMR_IDLE   = 2'b00,
    TMR_FETCH  = 2'b01,
    TMR_SAMPLE = 2'b11,
    TMR_COMMIT = 2'b10
  } tmr_state_t;

  function automatic logic [3:0] tmr_worse(input logic [3:0] a, input logic [3:0] b);
    return (b > a) ? b : a;
  endfunction

  function automatic logic tmr_id_ok(input logic [7:0] id);
    return (id >= TMR_ID_MIN) && (id <= TMR_ID_MAX);
  endfunction

endpackage

/* hw/tmr_pack_if.sv */
/*
  Carrier between the responder and its byte packer.
  Assumes both ends sit on the same clock; the path is combinational.
*/
`timescale 1ns/1ns
interface tmr_pack_if;
  logic [31:0] value;
  logic [2:0]  nbytes;
  logic        big_end;
  logic [7:0]  lane [4];

  modport packer (input value, input nbytes, input big_end, output lane);
  modport user   (output value, output nbytes, output big_end, input lane);
endinterface

/* hw/tmr_pack.sv */
/*
  Orders the bytes of one measured value into four lanes, lane 0 first on the wire.
  Assumes nbytes is 1 to 4; lanes past nbytes read zero.
*/
`timescale 1ns/1ns
module tmr_pack (
  tmr_pack_if.packer pk
);
  logic [2:0] src;

  always_comb begin
    src = 3'h0;
    for (int i = 0; i < 4; i++) begin
      // [R19] endian lane order
      if (pk.big_end) begin
        src = 3'(pk.nbytes - 3'h1 - 3'(i));
      end else begin
        src = 3'(i);
      end
      if (3'(i) < pk.nbytes) begin
        pk.lane[i] = pk.value[8*src[1:0] +: 8];
      end else begin
        pk.lane[i] = 8'h00;
      end
    end
  end
endmodule // tmr_pack

/* hw/tmr_responder.sv */
/*
  Telegram responder: request and response images as Avalon-MM registers,
  decode of the telegram types, frame table and value lookup.
  Assumes the measurement source answers meas_value, meas_bytes and meas_present
  for meas_id and meas_tag within one cycle, on core_clk.
*/
// Implementation choices: the address map and the Avalon-MM register port.
`timescale 1ns/1ns
module tmr_responder
  import tmr_pkg::*;
#(
  parameter int unsigned POLL_CYCLES = TMR_POLL_CYCLES
) (
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output      logic [31:0] avs_readdata,
  output      logic        avs_waitrequest,
  output      logic [5:0]  meas_id,
  output      logic [3:0]  meas_tag,
  input  wire logic [31:0] meas_value,
  input  wire logic [2:0]  meas_bytes,
  input  wire logic        meas_present,
  input  wire logic        refresh_failed,
  input  wire logic        param_set_bad,
  input  wire logic        external_fault,
  input  wire logic        internal_fault,
  input  wire logic        freq_high_limit,
  input  wire logic        freq_low_limit,
  input  wire logic        temp_high_limit,
  input  wire logic        volt_high_limit,
  input  wire logic        volt_low_limit,
  input  wire logic        power_factor_low_limit,
  input  wire logic        current_high_limit
);

  // ==========================================================
  // Storage
  logic [7:0]            req [TMR_TELE_BYTES];
  logic [7:0]            rsp [TMR_TELE_BYTES];
  logic [7:0]            ubuf [TMR_USER_BYTES];
  logic [5:0]            frame_number [TMR_FRAMES][TMR_ENTRIES];
  logic [2:0]            fr_cnt [TMR_FRAMES];
  logic [TMR_FRAMES-1:0] fr_def;
  logic                  big_endian;
  logic                  auto_poll;
  logic                  no_param;
  logic                  go_pend;
  logic [3:0]            last_status;
  tmr_state_t            state;
  logic [2:0]            x_type;
  logic [7:0]            x_id;
  logic [3:0]            x_tag;
  logic [1:0]            x_frame;
  logic [2:0]            idx;
  logic [2:0]            n_entries;
  logic [3:0]            acc;
  logic [3:0]            err;
  logic [31:0]           poll_cnt;
  logic                  poll_tick;

  logic                  wr_fire;
  logic [31:0]           rd_mux;
  logic                  start;
  logic                  poll_start;
  logic [2:0]            d_type;
  logic [7:0]            d_sel;
  logic [3:0]            d_err;
  logic                  d_lookup;
  logic                  d_frame_ok;
  logic                  set_frame_ok;
  logic [4:0]            sum_bytes;
  logic                  value_bad;
  logic [7:0]            common;

  tmr_pack_if pk ();

  tmr_pack u_pack (
    .pk (pk)
  );

  assign pk.value   = meas_value;
  assign pk.nbytes  = meas_bytes;
  assign pk.big_end = big_endian;

  // ==========================================================
  // Avalon-MM slave
  // One wait cycle per access: the answer is registered, so readdata and
  // the low waitrequest appear together one edge after the request.
  assign wr_fire = avs_write && !avs_waitrequest;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else if (!avs_waitrequest) begin
      avs_waitrequest <= 1'b1;
    end else if (avs_read || avs_write) begin
      avs_waitrequest <= 1'b0;
      avs_readdata    <= avs_read ? rd_mux : 32'h0000_0000;
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (avs_address[5:4] == TMR_REQ_BASE[5:4]) begin
      for (int k = 0; k < 4; k++) begin
        rd_mux[8*k +: 8] = req[{avs_address[3:2], 2'(k)}];
      end
    end else if (avs_address[5:4] == TMR_RSP_BASE[5:4]) begin
      // [R21] response image readback
      for (int k = 0; k < 4; k++) begin
        rd_mux[8*k +: 8] = rsp[{avs_address[3:2], 2'(k)}];
      end
    end else if (avs_address == TMR_CTRL_ADDR) begin
      rd_mux[TMR_CTRL_BIG]     = big_endian;
      rd_mux[TMR_CTRL_POLL]    = auto_poll;
      rd_mux[TMR_CTRL_NOPARAM] = no_param;
    end else if (avs_address == TMR_STAT_ADDR) begin
      rd_mux[TMR_STAT_BUSY]                 = (state != TMR_IDLE) || go_pend;
      rd_mux[TMR_STAT_LAST +: 4]            = last_status;
      rd_mux[TMR_STAT_DEF +: TMR_FRAMES]    = fr_def;
    end
  end

  // Request image, written by the head module side
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int b = 0; b < TMR_TELE_BYTES; b++) begin
        req[b] <= 8'h00;
      end
    end else if (wr_fire && avs_address[5:4] == TMR_REQ_BASE[5:4]) begin
      for (int k = 0; k < 4; k++) begin
        if (avs_byteenable[k]) begin
          req[{avs_address[3:2], 2'(k)}] <= avs_writedata[8*k +: 8];
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      big_endian <= TMR_BIG_RST;
      auto_poll  <= TMR_POLL_RST;
      no_param   <= TMR_NOPARAM_RST;
    end else if (wr_fire && avs_address == TMR_CTRL_ADDR && avs_byteenable[0]) begin
      big_endian <= avs_writedata[TMR_CTRL_BIG];
      auto_poll  <= avs_writedata[TMR_CTRL_POLL];
      no_param   <= avs_writedata[TMR_CTRL_NOPARAM];
    end
  end

  // Doorbell: a write of go during an exchange is kept, set beats clear
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      go_pend <= 1'b0;
    end else if (wr_fire && avs_address == TMR_CTRL_ADDR && avs_byteenable[0]
                 && avs_writedata[TMR_CTRL_GO]) begin
      go_pend <= 1'b1;
    end else if (start && !poll_start) begin
      go_pend <= 1'b0;
    end
  end

  // ==========================================================
  // Poll divider
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      poll_cnt  <= 32'h0000_0000;
      poll_tick <= 1'b0;
    end else if (!auto_poll || poll_cnt == 32'(POLL_CYCLES - 1)) begin
      poll_cnt  <= 32'h0000_0000;
      poll_tick <= auto_poll;
    end else begin
      poll_cnt  <= poll_cnt + 32'h0000_0001;
      poll_tick <= 1'b0;
    end
  end

  // [R14] automatic frame zero poll
  assign poll_start = (state == TMR_IDLE) && !go_pend && auto_poll && poll_tick;
  assign start      = (state == TMR_IDLE) && (go_pend || poll_start);

  // ==========================================================
  // Request decode
  always_comb begin
    // [R10] type field extract
    d_type     = poll_start ? TMR_TY_ZERO : req[0][TMR_TYPE_LSB +: 3];
    // [R13] zero frame targets frame 0
    d_sel      = (d_type == TMR_TY_ZERO) ? 8'h00 : req[1];
    d_frame_ok = (d_sel < 8'(TMR_FRAMES)) && fr_def[d_sel[1:0]];
    d_lookup   = 1'b0;
    // [R07] [R08] faults common to every exchange
    d_err = TMR_ST_OK;
    if (refresh_failed) d_err = tmr_worse(d_err, TMR_ST_REFRESH);
    if (param_set_bad)  d_err = tmr_worse(d_err, TMR_ST_BAD_PARAM);
    if (external_fault) d_err = tmr_worse(d_err, TMR_ST_EXTERNAL);
    if (internal_fault) d_err = tmr_worse(d_err, TMR_ST_INTERNAL);
    // [R11] [R12] type selection
    case (d_type)
      TMR_TY_VALUE, TMR_TY_ZERO, TMR_TY_RD_FRAME: begin
        // [R04] tag and length checks
        if (req[2][3:0] == 4'h0)         d_err = tmr_worse(d_err, TMR_ST_TAG);
        if (req[2][TMR_NIB_HI +: 4] != 4'h0) d_err = tmr_worse(d_err, TMR_ST_LENGTH);
        if (d_type == TMR_TY_VALUE) begin
          d_lookup = 1'b1;
        end else if (d_frame_ok) begin
          d_lookup = 1'b1;
        end else begin
          // [R05] undefined frame
          d_err = tmr_worse(d_err, TMR_ST_NO_FRAME);
        end
      end
      TMR_TY_SET_FRAME: begin
        // [R06] definition check
        if (d_sel >= 8'(TMR_FRAMES) || req[2][TMR_NIB_HI +: 4] == 4'h0
            || req[2][TMR_NIB_HI +: 4] > 4'(TMR_ENTRIES)) begin
          d_err = tmr_worse(d_err, TMR_ST_BAD_DEF);
        end else begin
          for (int e = 0; e < TMR_ENTRIES; e++) begin
            // [R22] identifier range
            if (4'(e) < req[2][TMR_NIB_HI +: 4] && !tmr_id_ok(req[TMR_HDR_BYTES + e])) begin
              d_err = tmr_worse(d_err, TMR_ST_BAD_DEF);
            end
          end
        end
      end
      // [R06] commands are not carried out here
      TMR_TY_CMD:   d_err = tmr_worse(d_err, TMR_ST_CMD_FAIL);
      TMR_TY_PARAM: begin
        if (no_param) d_err = tmr_worse(d_err, TMR_ST_BAD_TYPE);
      end
      // [R07] unsupported type
      default:      d_err = tmr_worse(d_err, TMR_ST_BAD_TYPE);
    endcase
  end

  assign set_frame_ok = start && d_type == TMR_TY_SET_FRAME && d_err == TMR_ST_OK;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      fr_def <= '0;
      for (int f = 0; f < TMR_FRAMES; f++) begin
        fr_cnt[f] <= 3'h0;
        for (int e = 0; e < TMR_ENTRIES; e++) begin
          frame_number[f][e] <= 6'h00;
        end
      end
    end else if (set_frame_ok) begin
      fr_def[d_sel[1:0]] <= 1'b1;
      fr_cnt[d_sel[1:0]] <= req[2][TMR_NIB_HI +: 3];
      for (int e = 0; e < TMR_ENTRIES; e++) begin
        frame_number[d_sel[1:0]][e] <= req[TMR_HDR_BYTES + e][5:0];
      end
    end
  end

  // ==========================================================
  // Exchange sequencer
  assign sum_bytes = 5'(acc) + 5'(meas_bytes);
  // [R22] value read identifier must be in range
  assign value_bad = !meas_present || meas_bytes == 3'h0 || meas_bytes > 3'(TMR_LANES)
                     || (x_type == TMR_TY_VALUE && !tmr_id_ok(x_id));

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state       <= TMR_IDLE;
      x_type      <= TMR_TY_ZERO;
      x_id        <= 8'h00;
      x_tag       <= 4'h0;
      x_frame     <= 2'h0;
      idx         <= 3'h0;
      n_entries   <= 3'h0;
      acc         <= 4'h0;
      err         <= TMR_ST_OK;
      last_status <= TMR_ST_OK;
      meas_id     <= 6'h00;
      meas_tag    <= 4'h0;
      for (int b = 0; b < TMR_USER_BYTES; b++) begin
        ubuf[b] <= 8'h00;
      end
    end else begin
      case (state)
        TMR_IDLE: begin
          if (start) begin
            // [R16] only type, byte 1 and byte 2 are used
            x_type    <= d_type;
            x_id      <= d_sel;
            x_tag     <= req[2][3:0];
            x_frame   <= d_sel[1:0];
            err       <= d_err;
            idx       <= 3'h0;
            acc       <= 4'h0;
            meas_tag  <= req[2][3:0];
            n_entries <= (d_type == TMR_TY_VALUE) ? 3'h1 : fr_cnt[d_sel[1:0]];
            meas_id   <= (d_type == TMR_TY_VALUE) ? d_sel[5:0] : frame_number[d_sel[1:0]][0];
            for (int b = 0; b < TMR_USER_BYTES; b++) begin
              ubuf[b] <= 8'h00;
            end
            state <= d_lookup ? TMR_FETCH : TMR_COMMIT;
          end
        end
        TMR_FETCH: begin
          state <= TMR_SAMPLE;
        end
        TMR_SAMPLE: begin
          if (value_bad) begin
            // [R05] missing measurand
            err <= tmr_worse(err, TMR_ST_NO_MEAS);
          end else if (sum_bytes > 5'(TMR_USER_BYTES)) begin
            // [R05] frame too big
            err <= tmr_worse(err, TMR_ST_TOO_BIG);
          end else begin
            acc <= sum_bytes[3:0];
            for (int i = 0; i < TMR_LANES; i++) begin
              if (3'(i) < meas_bytes) begin
                ubuf[4'(acc + 4'(i))] <= pk.lane[i];
              end
            end
          end
          idx <= idx + 3'h1;
          if (idx + 3'h1 < n_entries) begin
            meas_id <= frame_number[x_frame][2'(idx + 3'h1)];
            state   <= TMR_FETCH;
          end else begin
            state <= TMR_COMMIT;
          end
        end
        TMR_COMMIT: begin
          last_status <= err;
          state       <= TMR_IDLE;
        end
        default: state <= TMR_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Response image
  // [R09] common status flag byte
  assign common = {1'b0, current_high_limit, power_factor_low_limit, volt_low_limit,
                   volt_high_limit, temp_high_limit, freq_low_limit, freq_high_limit};

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int b = 0; b < TMR_TELE_BYTES; b++) begin
        rsp[b] <= 8'h00;
      end
    end else if (state == TMR_COMMIT) begin
      // [R23] all sixteen bytes at once
      // [R01] [R03] [R17] header byte 0 and echo
      rsp[0] <= {1'b0, x_type, err};
      rsp[1] <= x_id;
      // [R02] [R18] length and tag
      rsp[2] <= {(err == TMR_ST_OK) ? acc : 4'h0, x_tag};
      rsp[3] <= common;
      // [R20] twelve user bytes follow
      for (int b = 0; b < TMR_USER_BYTES; b++) begin
        rsp[TMR_HDR_BYTES + b] <= (err == TMR_ST_OK) ? ubuf[b] : 8'h00;
      end
    end
  end

endmodule // tmr_responder

/* bench/tmr_responder_checker.sv */
/*
  Bus and response-format checker for the telegram responder.
  Assumes it is bound to tmr_responder and sees only its register bus ports.
*/
`timescale 1ns/1ns
module tmr_responder_checker (
  input wire logic        core_clk,
  input wire logic        arst_n,
  input wire logic [5:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  // Answer to a read of response word 0
  logic rsp0;
  assign rsp0 = avs_read && !avs_waitrequest && (avs_address[5:2] == 4'h4);

  // ======================================
  // Handshake
  a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered in the next cycle");
  a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_wait_idle: assert property (!(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest)
    else $error("answer without a request");
  // Read data may only move with an answer, read or write
  a_rdata_hold: assert property (avs_waitrequest |-> $stable(avs_readdata))
    else $error("read data changed without a read answer");

  // ======================================
  // Response header
  a_err_no_len: assert property (rsp0 && avs_readdata[3:0] != 4'h0 |-> avs_readdata[23:20] == 4'h0)
    else $error("error response with nonzero length");
  a_type_msb: assert property (rsp0 |-> !avs_readdata[7])
    else $error("response byte 0 bit 7 set");
  a_common_msb: assert property (rsp0 |-> !avs_readdata[31])
    else $error("reserved common status bit set");
  a_code_known: assert property (rsp0 |-> !(avs_readdata[3:0] inside {4'hb, 4'hc, 4'hd}))
    else $error("undefined status code");
  a_value_len: assert property (rsp0 && avs_readdata[6:0] == 7'h10 |-> avs_readdata[23:20] inside {[4'h1:4'h4]})
    else $error("value response byte count out of range");

  c_error: cover property (rsp0 && avs_readdata[3:0] != 4'h0);
  c_value: cover property (rsp0 && avs_readdata[6:0] == 7'h10);
  c_frame: cover property (rsp0 && avs_readdata[6:4] == 3'h0 && avs_readdata[23:20] != 4'h0);
endmodule // tmr_responder_checker

bind tmr_responder tmr_responder_checker u_chk (
  .core_clk(core_clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest)
);

/* bench/tmr_meas_model.sv */
/*
  Measurement source model: knows two measurands, answers within the cycle.
  Assumes lookups come from the responder on the same clock.
*/
`timescale 1ns/1ns
module tmr_meas_model (
  input  wire logic [5:0]  meas_id,
  input  wire logic [3:0]  meas_tag,
  output      logic [31:0] meas_value,
  output      logic [2:0]  meas_bytes,
  output      logic        meas_present
);
  always_comb begin
    case (meas_id)
      6'h0e: {meas_present, meas_bytes, meas_value} = {1'b1, 3'h2, 32'h0000_0023};
      6'h05: {meas_present, meas_bytes, meas_value} = {1'b1, 3'h4, 32'h1122_3344};
      // Absent ids drive a moving pattern so stale data cannot pass
      default: {meas_present, meas_bytes, meas_value} = {1'b0, 3'h0, ~{22'h0, meas_tag, meas_id}};
    endcase
  end
endmodule // tmr_meas_model

/* bench/telegram_measurand_responder_tb.sv */
/*
  Self-checking bench for the telegram responder.
  Assumes the responder package and the measurement source model are compiled first.
*/
`timescale 1ns/1ns
module telegram_measurand_responder_tb
  import tmr_pkg::*;
;
  logic        core_clk      = 1'b0;
  logic        arst_n        = 1'b0;
  logic [5:0]  avs_address   = 6'h00;
  logic        avs_read      = 1'b0;
  logic        avs_write     = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  flt           = 4'h0;
  logic [6:0]  lim           = 7'h00;
  logic [2:0]  ctrl          = 3'h1;
  wire  logic [31:0] avs_readdata, meas_value;
  wire  logic [5:0]  meas_id;
  wire  logic [3:0]  meas_tag;
  wire  logic [2:0]  meas_bytes;
  wire  logic        avs_waitrequest, meas_present;
  int          fails         = 0;
  int          checked       = 0;
  // Entries: faults, no-param flag, bytes 2..0, expected byte 0
  localparam logic [39:0] ERR_TBL [17] = '{
    40'h00_00_0e_10_12, 40'h00_31_0e_10_13, 40'h00_30_0e_10_13, 40'h00_01_1e_10_16,
    40'h00_10_1e_10_16, 40'h10_01_0e_10_11, 40'h30_01_0e_10_1a, 40'h40_01_0e_10_1e,
    40'hc0_01_0e_10_1f, 40'h00_01_00_40_47, 40'h00_01_00_50_59, 40'h00_01_00_70_79,
    40'h00_00_00_30_38, 40'h00_01_02_20_25, 40'h00_01_00_00_05, 40'h01_01_00_60_69,
    40'h00_01_00_60_60};

  initial forever #10 core_clk = ~core_clk;

  tmr_responder #(.POLL_CYCLES(20)) uut (
    .core_clk(core_clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .meas_id(meas_id),
    .meas_tag(meas_tag), .meas_value(meas_value), .meas_bytes(meas_bytes),
    .meas_present(meas_present), .refresh_failed(flt[0]), .param_set_bad(flt[1]),
    .external_fault(flt[2]), .internal_fault(flt[3]), .freq_high_limit(lim[0]),
    .freq_low_limit(lim[1]), .temp_high_limit(lim[2]), .volt_high_limit(lim[3]),
    .volt_low_limit(lim[4]), .power_factor_low_limit(lim[5]), .current_high_limit(lim[6])
  );

  tmr_meas_model mdl (
    .meas_id(meas_id), .meas_tag(meas_tag), .meas_value(meas_value),
    .meas_bytes(meas_bytes), .meas_present(meas_present)
  );

  // ======================================
  // Shared tasks
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic wait_out();
    fails++;
    $display("CHECK FAILED at %0t: wait limit used up", $time);
    final_report();
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // One bus access; the edge after the answer separates it from the next one
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 64);
    q = avs_readdata;
    if (n >= 64) wait_out();
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic xchg(input logic [31:0] hdr, input logic [31:0] d0,
                      output logic [31:0] r0, output logic [31:0] r1);
    int n;
    logic [31:0] st;
    bus(1'b1, TMR_REQ_BASE, hdr, st);
    bus(1'b1, 6'h04, d0, st);
    bus(1'b1, TMR_CTRL_ADDR, {28'h0, ctrl, 1'b1}, st);
    n = 0;
    do begin
      bus(1'b0, TMR_STAT_ADDR, 32'h0, st);
      n++;
    end while (st[0] !== 1'b0 && n < 64);
    if (n >= 64) wait_out();
    bus(1'b0, TMR_RSP_BASE, 32'h0, r0);
    bus(1'b0, 6'h14, 32'h0, r1);
  endtask

  // ======================================
  // Scenarios
  task automatic t_regs();
    logic [31:0] q;
    bus(1'b0, TMR_CTRL_ADDR, 32'h0, q);
    check(q, 32'h0000_0002, "control after reset");
    bus(1'b1, TMR_RSP_BASE, 32'hdead_beef, q);
    bus(1'b0, TMR_RSP_BASE, 32'h0, q);
    check(q, 32'h0, "response image written");
    bus(1'b1, 6'h28, 32'hffff_ffff, q);
    bus(1'b0, 6'h28, 32'h0, q);
    check(q, 32'h0, "unmapped read");
  endtask

  task automatic t_value();
    logic [31:0] r0, r1;
    lim <= 7'h55;
    for (int b = 0; b < 2; b++) begin
      ctrl = {2'b00, b[0]};
      xchg(32'hff01_0e1f, 32'ha5a5_a5a5, r0, r1);
      check(r0, 32'h5521_0e10, "value header");
      check(r1, b ? 32'h0000_2300 : 32'h0000_0023, "two byte value");
      xchg(32'h0001_0510, 32'h0, r0, r1);
      check(r0, 32'h5541_0510, "four byte header");
      check(r1, b ? 32'h4433_2211 : 32'h1122_3344, "four byte value");
    end
    ctrl = 3'h1;
  endtask

  task automatic t_errors();
    logic [31:0] r0, r1;
    foreach (ERR_TBL[i]) begin
      flt <= ERR_TBL[i][39:36];
      ctrl = {ERR_TBL[i][32], 2'b01};
      xchg({8'h00, ERR_TBL[i][31:8]}, 32'h1234_5678, r0, r1);
      check(r0 & 32'h00f0_00ff, {24'h0, ERR_TBL[i][7:0]}, "status code");
      check(r1, 32'h0, "error user data");
    end
    flt <= 4'h0;
    ctrl = 3'h1;
  endtask

  task automatic t_frame();
    logic [31:0] r0, r1;
    xchg(32'h0020_0030, 32'h0000_050e, r0, r1);
    check(r0 & 32'h00f0_00ff, 32'h0000_0030, "frame set");
    for (int k = 0; k < 2; k++) begin
      xchg({24'h00_0100, k ? 8'h20 : 8'h00}, 32'h0, r0, r1);
      check(r0, {24'h55_6100, k ? 8'h20 : 8'h00}, "frame header");
      check(r1, 32'h2211_2300, "frame bytes");
      bus(1'b0, 6'h18, 32'h0, r1);
      check(r1, 32'h0000_4433, "frame tail");
    end
  endtask

  task automatic t_poll();
    logic [31:0] q;
    bus(1'b1, TMR_REQ_BASE, 32'h0001_0e10, q);
    ctrl = 3'h3;
    bus(1'b1, TMR_CTRL_ADDR, {28'h0, ctrl, 1'b0}, q);
    // Several poll periods of 20 cycles
    repeat (100) @(posedge core_clk);
    bus(1'b0, TMR_RSP_BASE, 32'h0, q);
    check(q, 32'h5561_0000, "automatic frame 0");
    ctrl = 3'h1;
    bus(1'b1, TMR_CTRL_ADDR, {28'h0, ctrl, 1'b0}, q);
  endtask

  initial begin
    repeat (16) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    t_regs();
    t_value();
    t_errors();
    t_frame();
    t_poll();
    final_report();
  end
endmodule // telegram_measurand_responder_tb
